// ==== verilog/wsr_watchdog_status.sv ====
`timescale 1ns/100ps
`include "wsr_consts.svh"
module wsr_watchdog_status (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire logic                 spi_cs_n_i,
	input  wire logic                 spi_sck_i,
	input  wire logic                 spi_sdi_i,
	output logic                      spi_sdo_o,
	output logic                      spi_sdo_oe_o,
	input  wire logic                 watchdog_disable_pin_i,
	input  wire logic                 main_supply_low_i,
	input  wire logic                 transceiver_supply_low_i,
	input  wire logic                 wake_input_one_pin_i,
	input  wire logic                 wake_input_two_pin_i,
	input  wire logic                 normal_mode_i,
	input  wire logic                 standby_mode_i,
	output wsr_pkg::wsr_wd_mode_t     watchdog_mode_o,
	output logic [2:0]                watchdog_period_select_o,
	output logic [12:0]               watchdog_period_ms_o,
	output logic                      soft_reset_o
);

	// one lane per pin: chip select, sck, data in and five status pins
	localparam int NSYNC = 8;

	logic [NSYNC-1:0]            pin_raw;
	logic [NSYNC-1:0]            sync1_reg;
	logic [NSYNC-1:0]            sync2_reg;
	logic                        cs_n_s;
	logic                        sck_s;
	logic                        sdi_s;
	logic                        watchdog_disable_pin;
	logic                        main_supply_low_flag;
	logic                        transceiver_supply_low_flag;
	logic                        wake_input_one_level;
	logic                        wake_input_two_level;

	assign pin_raw = {
		wake_input_two_pin_i,
		wake_input_one_pin_i,
		transceiver_supply_low_i,
		main_supply_low_i,
		watchdog_disable_pin_i,
		spi_sdi_i,
		spi_sck_i,
		spi_cs_n_i
	};

	// two-stage synchroniser per pin
	// chip select resets high and the rest low, the idle levels of the pins,
	// so no false frame edge follows reset
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync1_reg[gi] <= (gi == 0);
					sync2_reg[gi] <= (gi == 0);
				end else if (ce_i) begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign cs_n_s                      = sync2_reg[0];
	assign sck_s                       = sync2_reg[1];
	assign sdi_s                       = sync2_reg[2];
	assign watchdog_disable_pin        = sync2_reg[3];
	assign main_supply_low_flag        = sync2_reg[4];
	assign transceiver_supply_low_flag = sync2_reg[5];
	assign wake_input_one_level        = sync2_reg[6];
	assign wake_input_two_level        = sync2_reg[7];

	logic                        cs_n_d_reg;
	logic                        sck_d_reg;
	logic                        frame_start;
	logic                        frame_end;
	logic                        sck_rise;
	logic                        sck_fall;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_n_d_reg <= 1'b1;
			sck_d_reg  <= 1'b0;
		end else if (ce_i) begin
			cs_n_d_reg <= cs_n_s;
			sck_d_reg  <= sck_s;
		end
	end

	// sck edges count only while chip select is low
	assign frame_start = cs_n_d_reg & ~cs_n_s;
	assign frame_end   = ~cs_n_d_reg & cs_n_s;
	assign sck_rise    = ~cs_n_s & ~sck_d_reg & sck_s;
	assign sck_fall    = ~cs_n_s & sck_d_reg & ~sck_s;

	// stored fields
	logic                        read_only_access_flag_reg;
	logic                        watchdog_mode_select_reg;
	logic [2:0]                  watchdog_period_select_reg;
	logic [15:0]                 read_word;

	// status bits follow the synchronised pins; the word is snapshotted per frame
	assign read_word[`WSR_ADDR_MSB:`WSR_ADDR_LSB] = `WSR_OFFSET;
	assign read_word[`WSR_RDONLY_BIT]   = read_only_access_flag_reg;
	assign read_word[`WSR_MODE_SEL_BIT] = watchdog_mode_select_reg;
	assign read_word[`WSR_PERIOD_MSB:`WSR_PERIOD_LSB] = watchdog_period_select_reg;
	assign read_word[`WSR_OFF_FLAG_BIT] = watchdog_disable_pin;
	assign read_word[`WSR_MAIN_LOW_BIT] = main_supply_low_flag;
	assign read_word[`WSR_XCVR_LOW_BIT] = transceiver_supply_low_flag;
	assign read_word[`WSR_WL1_BIT] = wake_input_one_level;
	assign read_word[`WSR_WL2_BIT] = wake_input_two_level;
	assign read_word[`WSR_RSV_MSB:0] = 3'h0;

	// frame engine
	wsr_pkg::wsr_state_t         state_reg;
	wsr_pkg::wsr_state_t         state_next;
	logic [15:0]                 tx_reg;
	logic [15:0]                 rx_reg;
	logic [15:0]                 rx_next;
	logic [4:0]                  cnt_reg;
	logic                        addr_miss_reg;
	logic                        sdo_reg;
	logic                        hdr_bit;
	logic [2:0]                  hdr_addr;

	// the frame ends on any chip-select release, whatever the bit count
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			wsr_pkg::WSR_IDLE: begin
				if (frame_start) begin
					state_next = wsr_pkg::WSR_XFER;
				end
			end
			wsr_pkg::WSR_XFER: begin
				if (cs_n_s) begin
					state_next = wsr_pkg::WSR_IDLE;
				end
			end
			default: begin
				state_next = wsr_pkg::WSR_IDLE;
			end
		endcase
	end

	// header is complete on the third sampled bit, the one being taken now
	assign rx_next  = {rx_reg[14:0], sdi_s};
	assign hdr_bit  = sck_fall & (cnt_reg == `WSR_HDR_LAST);
	assign hdr_addr = {rx_reg[1:0], sdi_s};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= wsr_pkg::WSR_IDLE;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	// outgoing bit moves on sck rising, incoming bit taken on sck falling
	// bit 15 stays in tx_reg for the first sck rise: the master samples on the
	// fall after that rise, so consuming it at frame start would drop it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_reg  <= 16'h0000;
			sdo_reg <= 1'b0;
		end else if (ce_i) begin
			if (frame_start) begin
				tx_reg  <= read_word;
				sdo_reg <= read_word[15];
			end else if (sck_rise && state_reg == wsr_pkg::WSR_XFER) begin
				tx_reg  <= {tx_reg[14:0], 1'b0};
				sdo_reg <= tx_reg[15];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_reg  <= 16'h0000;
			cnt_reg <= 5'h00;
		end else if (ce_i) begin
			if (frame_start) begin
				rx_reg  <= 16'h0000;
				cnt_reg <= 5'h00;
			end else if (sck_fall && state_reg == wsr_pkg::WSR_XFER) begin
				rx_reg <= rx_next;
				// saturate so an overlong frame never wraps back to a full count
				if (cnt_reg != `WSR_CNT_CAP) begin
					cnt_reg <= cnt_reg + 5'h01;
				end
			end
		end
	end

	// release the data line once the header names another register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_miss_reg <= 1'b0;
		end else if (ce_i) begin
			if (frame_start) begin
				addr_miss_reg <= 1'b0;
			end else if (hdr_bit && state_reg == wsr_pkg::WSR_XFER) begin
				addr_miss_reg <= (hdr_addr != `WSR_OFFSET);
			end
		end
	end

	assign spi_sdo_o    = sdo_reg;
	assign spi_sdo_oe_o = (state_reg == wsr_pkg::WSR_XFER) & ~cs_n_s & ~addr_miss_reg;

	// commit on chip-select release after exactly one full frame
	// a frame cut short or overlong leaves every field untouched
	logic                        commit;
	logic                        commit_rw;

	assign commit = frame_end && state_reg == wsr_pkg::WSR_XFER
		&& cnt_reg == `WSR_FRAME_BITS
		&& rx_reg[`WSR_ADDR_MSB:`WSR_ADDR_LSB] == `WSR_OFFSET;
	assign commit_rw = commit & ~rx_reg[`WSR_RDONLY_BIT];

	// the access flag follows every addressed frame, the rest only read/write frames
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			read_only_access_flag_reg  <= `WSR_RDONLY_RST;
			watchdog_mode_select_reg   <= `WSR_MODE_SEL_RST;
			watchdog_period_select_reg <= `WSR_PERIOD_RST;
		end else if (ce_i) begin
			if (commit) begin
				read_only_access_flag_reg <= rx_reg[`WSR_RDONLY_BIT];
			end
			if (commit_rw) begin
				watchdog_mode_select_reg   <= rx_reg[`WSR_MODE_SEL_BIT];
				watchdog_period_select_reg <= rx_reg[`WSR_PERIOD_MSB:`WSR_PERIOD_LSB];
			end
		end
	end

	// software reset request when the status bit is written as one
	// commit lasts one cycle, so the request is a one-cycle pulse
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			soft_reset_o <= 1'b0;
		end else if (ce_i) begin
			soft_reset_o <= commit_rw & rx_reg[`WSR_OFF_FLAG_BIT];
		end
	end

	// watchdog mode and nominal period
	wsr_pkg::wsr_wd_mode_t       mode_next;
	logic [12:0]                 period_ms_next;

	// a high disable pin forces the watchdog off whatever the mode select says
	always_comb begin
		mode_next = wsr_pkg::WSR_WD_OFF;
		if (watchdog_disable_pin) begin
			mode_next = wsr_pkg::WSR_WD_OFF;
		end else if (normal_mode_i) begin
			if (watchdog_mode_select_reg) begin
				mode_next = wsr_pkg::WSR_WD_TIMEOUT;
			end else begin
				mode_next = wsr_pkg::WSR_WD_WINDOW;
			end
		end else if (standby_mode_i) begin
			if (watchdog_mode_select_reg) begin
				mode_next = wsr_pkg::WSR_WD_OFF;
			end else begin
				mode_next = wsr_pkg::WSR_WD_TIMEOUT;
			end
		end
	end

	// the two longest periods break the doubling pattern, hence a table
	always_comb begin
		case (watchdog_period_select_reg)
			3'h0: period_ms_next = `WSR_MS_000;
			3'h1: period_ms_next = `WSR_MS_001;
			3'h2: period_ms_next = `WSR_MS_010;
			3'h3: period_ms_next = `WSR_MS_011;
			3'h4: period_ms_next = `WSR_MS_100;
			3'h5: period_ms_next = `WSR_MS_101;
			3'h6: period_ms_next = `WSR_MS_110;
			default: period_ms_next = `WSR_MS_111;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			watchdog_mode_o          <= wsr_pkg::WSR_WD_OFF;
			watchdog_period_select_o <= `WSR_PERIOD_RST;
			watchdog_period_ms_o     <= `WSR_MS_100;
		end else if (ce_i) begin
			watchdog_mode_o          <= mode_next;
			watchdog_period_select_o <= watchdog_period_select_reg;
			watchdog_period_ms_o     <= period_ms_next;
		end
	end

endmodule

// ==== verilog/wsr_consts.svh ====
// Function
// - top three frame bits 000 select this register
// - bit 12 flags read-only, resets to 0
// - read-only frame returns content, alters nothing; here it still stores its bit 12 flag as 1
// - select 0: Normal window, Standby timeout
// - select 1: Normal timeout, Standby off
// - period field 10:8, reset to 100
// - bit 7 reads 0 while disable pin low
// - bit 7 reads 1 when disabled; writing resets
// - bit 6 reports main regulator undervoltage
// - bit 5 reports transceiver regulator undervoltage
// - bit 4 reports first wake input level
// - bit 3 reports second wake input level
// - sample on falling edge, shift on rising
`ifndef WSR_CONSTS_SVH
`define WSR_CONSTS_SVH
`define WSR_OFFSET       3'h0
`define WSR_ADDR_MSB     15
`define WSR_ADDR_LSB     13
`define WSR_RDONLY_BIT   12
`define WSR_MODE_SEL_BIT 11
`define WSR_PERIOD_MSB   10
`define WSR_PERIOD_LSB   8
`define WSR_OFF_FLAG_BIT 7
`define WSR_MAIN_LOW_BIT 6
`define WSR_XCVR_LOW_BIT 5
`define WSR_WL1_BIT      4
`define WSR_WL2_BIT      3
`define WSR_RSV_MSB      2
`define WSR_RDONLY_RST   1'h0
`define WSR_MODE_SEL_RST 1'h0
`define WSR_PERIOD_RST   3'h4
`define WSR_FRAME_BITS   5'h10
`define WSR_CNT_CAP      5'h11
`define WSR_HDR_LAST     5'h02
`define WSR_MS_000       13'h0008
`define WSR_MS_001       13'h0010
`define WSR_MS_010       13'h0020
`define WSR_MS_011       13'h0040
`define WSR_MS_100       13'h0080
`define WSR_MS_101       13'h0100
`define WSR_MS_110       13'h0400
`define WSR_MS_111       13'h1000
`endif

// ==== verilog/wsr_pkg.sv ====
package wsr_pkg;
	typedef enum logic [1:0] {
		WSR_WD_OFF,
		WSR_WD_WINDOW,
		WSR_WD_TIMEOUT
	} wsr_wd_mode_t;
	typedef enum logic {
		WSR_IDLE,
		WSR_XFER
	} wsr_state_t;
endpackage

// ==== test/wsr_watchdog_status_props.sv ====
`timescale 1ns/100ps
module wsr_watchdog_status_props (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  spi_cs_n_i,
	input wire logic                  spi_sdo_oe_o,
	input wire logic                  watchdog_disable_pin_i,
	input wire logic                  normal_mode_i,
	input wire logic                  standby_mode_i,
	input wire wsr_pkg::wsr_wd_mode_t watchdog_mode_o,
	input wire logic [2:0]            watchdog_period_select_o,
	input wire logic [12:0]           watchdog_period_ms_o,
	input wire logic                  soft_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	function automatic logic [12:0] ms_of(input logic [2:0] s);
		return (s == 3'h6) ? 13'h0400 : (s == 3'h7) ? 13'h1000 : 13'h0008 << s;
	endfunction
	property p_ms;
		watchdog_period_select_o == $past(watchdog_period_select_o)
			|-> watchdog_period_ms_o == ms_of(watchdog_period_select_o);
	endproperty
	a_ms: assert property (p_ms) else $error("period in ms wrong");
	property p_rst;
		$fell(rst_i) |-> watchdog_period_select_o == 3'h4 && watchdog_period_ms_o == 13'h0080 && !soft_reset_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_sr1;
		soft_reset_o |=> !soft_reset_o;
	endproperty
	a_sr1: assert property (p_sr1) else $error("soft reset too long");
	property p_src;
		$rose(soft_reset_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
	endproperty
	a_src: assert property (p_src) else $error("soft reset inside frame");
	property p_sel;
		$changed(watchdog_period_select_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
	endproperty
	a_sel: assert property (p_sel) else $error("period changed inside frame");
	property p_oe;
		spi_cs_n_i [*3] |-> !spi_sdo_oe_o;
	endproperty
	a_oe: assert property (p_oe) else $error("sdo driven while deselected");
	property p_off;
		watchdog_disable_pin_i [*4] |-> watchdog_mode_o == wsr_pkg::WSR_WD_OFF;
	endproperty
	a_off: assert property (p_off) else $error("watchdog on while pin high");
	property p_none;
		(!normal_mode_i && !standby_mode_i) [*2] |-> watchdog_mode_o == wsr_pkg::WSR_WD_OFF;
	endproperty
	a_none: assert property (p_none) else $error("watchdog on outside modes");
	property p_nowin;
		(!normal_mode_i) [*2] |-> watchdog_mode_o != wsr_pkg::WSR_WD_WINDOW;
	endproperty
	a_nowin: assert property (p_nowin) else $error("window outside normal");
endmodule
bind wsr_watchdog_status wsr_watchdog_status_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i), .spi_sdo_oe_o(spi_sdo_oe_o),
	.watchdog_disable_pin_i(watchdog_disable_pin_i), .normal_mode_i(normal_mode_i),
	.standby_mode_i(standby_mode_i), .watchdog_mode_o(watchdog_mode_o),
	.watchdog_period_select_o(watchdog_period_select_o), .watchdog_period_ms_o(watchdog_period_ms_o),
	.soft_reset_o(soft_reset_o)
);

// ==== test/wsr_spi_master.sv ====
`timescale 1ns/100ps
module wsr_spi_master (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      sdi_o
);
	logic last = 1'h0;
	initial begin
		cs_n_o = 1'h1;
		sck_o = 1'h0;
		sdi_o = 1'h0;
	end
	// msb first, 8 clk per sck half period
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n_o <= 1'h0;
		repeat (8) @(posedge clk_i);
		for (int i = 15; i >= 0; i--) begin
			sck_o <= 1'h1;
			sdi_o <= tx[i];
			repeat (8) @(posedge clk_i);
			sck_o <= 1'h0;
			@(negedge clk_i);
			// a released line shows no stale value
			last = sdo_oe_i ? sdo_i : ~last;
			rx[i] = last;
			repeat (8) @(posedge clk_i);
		end
		cs_n_o <= 1'h1;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

// ==== test/wsr_watchdog_status_test.sv ====
`timescale 1ns/100ps
module wsr_watchdog_status_test;
	logic                  clk_i = 1'h0;
	logic                  rst_i = 1'h1;
	logic [4:0]            pins = 5'h00;
	logic                  nrm = 1'h1;
	logic                  stb = 1'h0;
	logic                  ce = 1'h1;
	logic                  cs_n, sck, sdi, sdo, sdo_oe, srst;
	logic [2:0]            sel;
	logic [12:0]           ms;
	wsr_pkg::wsr_wd_mode_t mode;
	logic [15:0]           rx;
	int                    errors = 0;
	int                    checked = 0;
	int                    pulses = 0;
	initial forever #5 clk_i = ~clk_i;
	wsr_watchdog_status uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .spi_cs_n_i(cs_n), .spi_sck_i(sck),
		.spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .watchdog_disable_pin_i(pins[4]),
		.main_supply_low_i(pins[3]), .transceiver_supply_low_i(pins[2]), .wake_input_one_pin_i(pins[1]),
		.wake_input_two_pin_i(pins[0]), .normal_mode_i(nrm), .standby_mode_i(stb), .watchdog_mode_o(mode),
		.watchdog_period_select_o(sel), .watchdog_period_ms_o(ms), .soft_reset_o(srst));
	wsr_spi_master m (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
	always @(posedge clk_i) if (srst === 1'h1) pulses++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(input wsr_pkg::wsr_wd_mode_t exp);
		checked++;
		if (mode !== exp) begin
			errors++;
			$display("mismatch at %0t: mode %0d want %0d", $time, mode, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk(16'(sel), 16'h0004);
		m.xfer(16'h1000, rx);
		chk(rx, 16'h0400);
		chk_mode(wsr_pkg::WSR_WD_WINDOW);
		$display("test defaults done");
		for (int k = 0; k < 8; k++) begin
			m.xfer({5'h00, 3'(k), 8'h07}, rx);
			chk(rx, (k == 0) ? 16'h1400 : {5'h00, 3'(k - 1), 8'h00});
			chk(16'(sel), 16'(k));
			chk(16'(ms), (k < 6) ? 16'h0008 << k : (k == 6) ? 16'h0400 : 16'h1000);
		end
		$display("test period done");
		m.xfer(16'h1200, rx);
		chk(16'(sel), 16'h0007);
		m.xfer(16'h2300, rx);
		chk(16'(sel), 16'h0007);
		m.xfer(16'h1000, rx);
		chk(rx, 16'h1700);
		$display("test access done");
		m.xfer(16'h0800, rx);
		chk_mode(wsr_pkg::WSR_WD_TIMEOUT);
		stb <= 1'h1;
		nrm <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk_mode(wsr_pkg::WSR_WD_OFF);
		m.xfer(16'h0000, rx);
		chk_mode(wsr_pkg::WSR_WD_TIMEOUT);
		stb <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk_mode(wsr_pkg::WSR_WD_OFF);
		nrm <= 1'h1;
		$display("test modes done");
		for (int p = 0; p < 2; p++) begin
			pins <= p ? 5'h05 : 5'h1A;
			repeat (4) @(posedge clk_i);
			m.xfer(16'h1000, rx);
			chk(16'(rx[7:0]), p ? 16'h0028 : 16'h00D0);
			if (p == 0) chk_mode(wsr_pkg::WSR_WD_OFF);
		end
		$display("test status done");
		pulses = 0;
		m.xfer(16'h0080, rx);
		m.xfer(16'h1080, rx);
		chk(16'(pulses), 16'h0001);
		m.xfer(16'h0300, rx);
		chk(16'(sel), 16'h0003);
		ce <= 1'h0;
		m.xfer(16'h0500, rx);
		ce <= 1'h1;
		repeat (4) @(posedge clk_i);
		chk(16'(sel), 16'h0003);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk(16'(sel), 16'h0004);
		$display("test soft reset done");
		tally_and_finish;
	end
endmodule
